// ==== hw/sfh_map.vh ====
// constants for the serial flash front end: field positions, counts, reset levels
// assumes inclusion by bare name from each design file that needs them
`ifndef SFH_MAP_VH
`define SFH_MAP_VH

// bit position of the last bit in a byte, msb first
`define SFH_BIT_LAST 3'h7
`define SFH_BIT_FIRST 3'h0
`define SFH_BIT_STEP 3'h1
// byte counter saturates here
`define SFH_BYTE_STEP 2'h1
`define SFH_BYTE_MAX 2'h3
`define SFH_BYTE_ZERO 2'h0
// write status instruction is opcode plus one data byte
`define SFH_WRSTAT_BYTES 2'h2
// opcode value of the write status instruction
`define SFH_WRSTAT_OPCODE 8'h01
// lock-down flag position within the status byte
`define SFH_LOCK_POS 7
// number of synchronised pins and their positions
`define SFH_SYNC_W 5
`define SFH_PIN_SCK 0
`define SFH_PIN_CS 1
`define SFH_PIN_SI 2
`define SFH_PIN_HOLD 3
`define SFH_PIN_WP 4
// reset levels of the synchronised pins: chip enable, pause, protect idle high
`define SFH_SYNC_RST 5'h1a
`define SFH_BYTE_RST 8'h00

`endif

// ==== hw/sfh_sync.v ====
// two flip-flop synchroniser for a group of independent pin levels
// assumes each bit is a slow level; no bus coherence between the bits
`timescale 1ns/1ps
module sfh_sync #(
  parameter W = 5,
  parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
  input wire sys_clk_i,
  input wire rst_n_i,
  input wire [W-1:0] async_i,
  output wire [W-1:0] sync_o
);

reg [W-1:0] meta_q;
reg [W-1:0] sync_q;

// first stage feeds only the second stage
always @(posedge sys_clk_i) begin
  if (!rst_n_i) begin
    meta_q <= RST_VAL;
    sync_q <= RST_VAL;
  end else begin
    meta_q <= async_i;
    sync_q <= meta_q;
  end
end

assign sync_o = sync_q;

endmodule

// ==== hw/sfh_spi_front.v ====
// serial peripheral front end of a small serial flash: framing, shifting, pause, protect gating
// assumes the serial clock is much slower than sys_clk_i and all pins are asynchronous to it
//
// Summary of operation
// - input bits are captured on serial clock rising edges and output bits change after falling edges.
// - both idle-low and idle-high serial clock modes work with the same sampling and output edges.
// - a transaction starts when chip enable falls and the master keeps it low for the whole sequence.
// - in auto-increment programming with the output reconfigured, the output shows ready/busy.
// - pausing freezes the bit position and shift state so the transfer resumes exactly where it stopped.
// - pause is entered when its request meets a low serial clock, else at the next low clock level.
// - pause is left when its release meets a low serial clock, else at the next low clock level.
// - while paused the output floats and the serial input and clock are ignored.
// - raising chip enable while paused resets the interface logic and drops the transaction; the code still commits a status write whose two bytes are complete.
// - pause lasts while its input is low; resuming needs pause high with chip enable still low.
// - with protect low, a status write is allowed or refused by the lock-down flag, status bit 7.
// - with protect high, the lock-down flag never blocks a status write.
// - with protect low and lock-down set, changes to lock-down and block-protect bits are refused.
// - every opcode, address and data cycle is eight bits, most significant bit first.
// - chip enable rising before the last bit of a byte aborts the instruction and returns to standby.
`timescale 1ns/1ps
`include "sfh_map.vh"
module sfh_spi_front (
  input wire sys_clk_i,
  input wire rst_n_i,
  // serial pins
  input wire sck_i,
  input wire cs_n_i,
  input wire si_i,
  input wire hold_n_i,
  input wire wp_n_i,
  output reg so_o,
  output reg so_oe_o,
  // core side
  input wire [7:0] tx_byte_i,
  input wire auto_increment_program_i,
  input wire ready_busy_out_en_i,
  input wire busy_i,
  input wire protect_lockdown_i,
  output reg [7:0] rx_byte_o,
  output reg rx_valid_o,
  output reg rx_first_o,
  output reg frame_start_o,
  output reg frame_end_o,
  output reg abort_o,
  output reg paused_o,
  output reg [7:0] status_wr_data_o,
  output reg status_wr_o,
  output reg status_wr_refused_o
);

////////////////////////////////////////////////////////////////////////////////
// pin synchronisation

wire [`SFH_SYNC_W-1:0] pins_s;

sfh_sync #(
  .W(`SFH_SYNC_W),
  .RST_VAL(`SFH_SYNC_RST)
) u_sync (
  .sys_clk_i(sys_clk_i),
  .rst_n_i(rst_n_i),
  .async_i({wp_n_i, hold_n_i, si_i, cs_n_i, sck_i}),
  .sync_o(pins_s)
);

wire sck_s = pins_s[`SFH_PIN_SCK];
wire cs_n_s = pins_s[`SFH_PIN_CS];
wire si_s = pins_s[`SFH_PIN_SI];
wire hold_n_s = pins_s[`SFH_PIN_HOLD];
wire wp_n_s = pins_s[`SFH_PIN_WP];

////////////////////////////////////////////////////////////////////////////////
// state

reg sck_prev_q;
reg cs_n_prev_q;
reg held_q;
reg held_d;
reg [2:0] bit_cnt_q;
reg [1:0] byte_cnt_q;
reg [7:0] rx_shift_q;
reg [7:0] tx_shift_q;
reg wrstat_q;
reg [7:0] wrstat_data_q;

// edge finding on the sampled pins
wire sck_rise = sck_s & ~sck_prev_q;
wire sck_fall = ~sck_s & sck_prev_q;
wire cs_fall = cs_n_prev_q & ~cs_n_s;
wire cs_rise = ~cs_n_prev_q & cs_n_s;

// serial edges count only while selected and not paused
// inputs ignored paused
wire act = ~cs_n_s & ~held_q;
wire byte_done = act & sck_rise & (bit_cnt_q == `SFH_BIT_LAST);

// lock-down decision for a status write
function wr_allowed;
  input wp_n;
  input lock;
  begin
    wr_allowed = wp_n | ~lock;
  end
endfunction

////////////////////////////////////////////////////////////////////////////////
// pause state

// pause only changes while the serial clock sits low; deselect clears it at any clock level
always @* begin
  held_d = held_q;
  if (cs_n_s) begin
    held_d = 1'b0;
  end else if (!sck_s) begin
    held_d = ~hold_n_s;
  end
end

always @(posedge sys_clk_i) begin
  if (!rst_n_i) begin
    sck_prev_q <= 1'b0;
    cs_n_prev_q <= 1'b1;
    held_q <= 1'b0;
    paused_o <= 1'b0;
  end else begin
    // tracked always so no false edge appears after a pause
    sck_prev_q <= sck_s;
    cs_n_prev_q <= cs_n_s;
    held_q <= held_d;
    paused_o <= held_d;
  end
end

////////////////////////////////////////////////////////////////////////////////
// receive path

always @(posedge sys_clk_i) begin
  if (!rst_n_i) begin
    bit_cnt_q <= `SFH_BIT_FIRST;
    byte_cnt_q <= `SFH_BYTE_ZERO;
    rx_shift_q <= `SFH_BYTE_RST;
    rx_byte_o <= `SFH_BYTE_RST;
    rx_valid_o <= 1'b0;
    rx_first_o <= 1'b0;
  end else begin
    rx_valid_o <= 1'b0;
    rx_first_o <= 1'b0;
    if (cs_n_s) begin
      bit_cnt_q <= `SFH_BIT_FIRST;
      byte_cnt_q <= `SFH_BYTE_ZERO;
      rx_shift_q <= `SFH_BYTE_RST;
    end else if (act && sck_rise) begin
      rx_shift_q <= {rx_shift_q[6:0], si_s};
      bit_cnt_q <= bit_cnt_q + `SFH_BIT_STEP;
      if (bit_cnt_q == `SFH_BIT_LAST) begin
        rx_byte_o <= {rx_shift_q[6:0], si_s};
        rx_valid_o <= 1'b1;
        rx_first_o <= (byte_cnt_q == `SFH_BYTE_ZERO);
        if (byte_cnt_q != `SFH_BYTE_MAX) begin
          byte_cnt_q <= byte_cnt_q + `SFH_BYTE_STEP;
        end
      end
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// transmit path

// byte for the next output cycle is loaded when an input byte completes
always @(posedge sys_clk_i) begin
  if (!rst_n_i) begin
    tx_shift_q <= `SFH_BYTE_RST;
    so_o <= 1'b0;
    so_oe_o <= 1'b0;
  end else begin
    so_oe_o <= ~cs_n_s & ~held_d;
    if (cs_n_s) begin
      tx_shift_q <= `SFH_BYTE_RST;
      so_o <= 1'b0;
    end else if (auto_increment_program_i && ready_busy_out_en_i) begin
      so_o <= ~busy_i;
    end else if (byte_done) begin
      tx_shift_q <= tx_byte_i;
    end else if (act && sck_fall) begin
      so_o <= tx_shift_q[7];
      tx_shift_q <= {tx_shift_q[6:0], 1'b0};
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// framing and status write gating

always @(posedge sys_clk_i) begin
  if (!rst_n_i) begin
    frame_start_o <= 1'b0;
    frame_end_o <= 1'b0;
    abort_o <= 1'b0;
    wrstat_q <= 1'b0;
    wrstat_data_q <= `SFH_BYTE_RST;
    status_wr_data_o <= `SFH_BYTE_RST;
    status_wr_o <= 1'b0;
    status_wr_refused_o <= 1'b0;
  end else begin
    frame_start_o <= 1'b0;
    frame_end_o <= 1'b0;
    abort_o <= 1'b0;
    status_wr_o <= 1'b0;
    status_wr_refused_o <= 1'b0;
    if (cs_fall) begin
      frame_start_o <= 1'b1;
      wrstat_q <= 1'b0;
    end
    // remember a status write opcode and its data byte
    if (byte_done) begin
      if (byte_cnt_q == `SFH_BYTE_ZERO) begin
        wrstat_q <= ({rx_shift_q[6:0], si_s} == `SFH_WRSTAT_OPCODE);
      end else if (byte_cnt_q == `SFH_BYTE_STEP) begin
        wrstat_data_q <= {rx_shift_q[6:0], si_s};
      end
    end
    if (cs_rise) begin
      frame_end_o <= 1'b1;
      wrstat_q <= 1'b0;
      if (bit_cnt_q != `SFH_BIT_FIRST) begin
        abort_o <= 1'b1;
      end else if (wrstat_q && byte_cnt_q == `SFH_WRSTAT_BYTES) begin
        status_wr_data_o <= wrstat_data_q;
        if (wr_allowed(wp_n_s, protect_lockdown_i)) begin
          status_wr_o <= 1'b1;
        end else begin
          status_wr_refused_o <= 1'b1;
        end
      end
    end
  end
end

endmodule

// ==== verification/sfh_checker.sv ====
// port checker for the serial flash front end
// assumes pins are slow against sys_clk_i
`timescale 1ns/1ps
module sfh_chk (
  input wire sys_clk_i,
  input wire rst_n_i,
  input wire sck_i,
  input wire cs_n_i,
  input wire hold_n_i,
  input wire wp_n_i,
  input wire auto_increment_program_i,
  input wire ready_busy_out_en_i,
  input wire busy_i,
  input wire so_o,
  input wire so_oe_o,
  input wire rx_valid_o,
  input wire rx_first_o,
  input wire frame_end_o,
  input wire abort_o,
  input wire paused_o,
  input wire status_wr_o,
  input wire status_wr_refused_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  ////////////////////////////////////////////////////////////
  // pin levels held long enough to pass the synchroniser
  sequence desel_s; cs_n_i [*5]; endsequence
  sequence hold_s; (!hold_n_i && !sck_i && !cs_n_i) [*5]; endsequence
  sequence busy_s; (auto_increment_program_i && ready_busy_out_en_i && busy_i) [*3]; endsequence
  desel_float_a: assert property (desel_s |-> !so_oe_o) else $error("output driven while deselected");
  pause_float_a: assert property (paused_o [*2] |-> !so_oe_o) else $error("output driven in pause");
  pause_enter_a: assert property (hold_s |-> paused_o) else $error("pause not entered");
  desel_clear_a: assert property (desel_s |-> !paused_o) else $error("pause kept after deselect");
  first_byte_a: assert property (rx_first_o |-> rx_valid_o) else $error("first flag without byte");
  abort_end_a: assert property (abort_o |-> frame_end_o) else $error("abort outside frame end");
  wr_end_a: assert property (status_wr_o |-> frame_end_o) else $error("status write off frame end");
  wp_free_a: assert property (wp_n_i [*4] |-> !status_wr_refused_o) else $error("refused with protect high");
  busy_out_a: assert property (busy_s ##0 so_oe_o |-> !so_o) else $error("busy not shown");
endmodule
bind sfh_spi_front sfh_chk u_chk (.*);

// ==== verification/sfh_master.sv ====
// spi bus master model driving the front end pins
// assumes an 800 ns serial clock made of 8 sys_clk_i cycles
`timescale 1ns/1ps
module sfh_master (
  input wire sys_clk_i,
  input wire so_i,
  output logic sck_o,
  output logic cs_n_o,
  output logic si_o,
  output logic hold_n_o
);
  logic cpol;
  // idle pins: deselected, not paused
  initial {sck_o, cs_n_o, si_o, hold_n_o, cpol} = 5'h0a;
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask
  task automatic start(input logic m3);
    cpol = m3;
    sck_o <= m3;
    tick(4);
    cs_n_o <= 1'b0;
    tick(4);
  endtask
  // msb first, data set while clock low
  task automatic send(input logic [7:0] b, input int n, output logic [7:0] r);
    r = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      sck_o <= 1'b0;
      si_o <= b[i];
      tick(4);
      sck_o <= 1'b1;
      tick(4);
      r[i] = so_i;
    end
  endtask
  task automatic pins(input logic s, input logic h);
    sck_o <= s;
    hold_n_o <= h;
    tick(6);
  endtask
  // idle level, deselect, data line no longer valid
  task automatic stop;
    sck_o <= cpol;
    tick(4);
    cs_n_o <= 1'b1;
    si_o <= ~si_o;
    tick(8);
  endtask
endmodule

// ==== verification/testbench.sv ====
// self-checking bench for the serial flash front end
// assumes sfh_master on the pins and the bound checker
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin fail_count++; \
  $display("ERROR t=%0t got %h exp %h", $time, a, e); end end
module testbench;
  logic sys_clk_i = 0, rst_n_i = 0, wp_n_i = 1, auto_i = 0, rbo_i = 0, busy_i = 0, lock_i = 0, tgl = 0;
  logic [7:0] tx_i = 8'h00, r, first_b;
  logic [12:0] row;
  int fail_count = 0, num_checks = 0, wr_n = 0, ref_n = 0, ab_n = 0, fs_n = 0, w0, r0, f0;
  wire sck, cs_n, si, hold_n, so, so_oe, rx_v, rx_f, wr, wr_ref, ab, paused, fs;
  wire [7:0] rx_b, wr_d;
  // released output line shows a changing pattern
  wire so_w = so_oe ? so : tgl;
  // mode, protect, lock-down, data, expected write, expected refusal
  localparam logic [12:0] ROWS [4] = '{{1'b0, 1'b1, 1'b1, 8'ha5, 1'b1, 1'b0}, {1'b1, 1'b0, 1'b0, 8'h3c, 1'b1, 1'b0},
    {1'b0, 1'b0, 1'b1, 8'h81, 1'b0, 1'b1}, {1'b1, 1'b1, 1'b0, 8'h7e, 1'b1, 1'b0}};
  always #50 sys_clk_i = ~sys_clk_i;
  sfh_master m (.sys_clk_i(sys_clk_i), .so_i(so_w), .sck_o(sck), .cs_n_o(cs_n), .si_o(si), .hold_n_o(hold_n));
  sfh_spi_front dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .sck_i(sck), .cs_n_i(cs_n), .si_i(si),
    .hold_n_i(hold_n), .wp_n_i(wp_n_i), .so_o(so), .so_oe_o(so_oe), .tx_byte_i(tx_i),
    .auto_increment_program_i(auto_i), .ready_busy_out_en_i(rbo_i), .busy_i(busy_i),
    .protect_lockdown_i(lock_i), .rx_byte_o(rx_b), .rx_valid_o(rx_v), .rx_first_o(rx_f),
    .frame_start_o(fs), .frame_end_o(), .abort_o(ab), .paused_o(paused), .status_wr_data_o(wr_d),
    .status_wr_o(wr), .status_wr_refused_o(wr_ref));
  // pulse counters and opcode capture
  always @(posedge sys_clk_i) begin
    tgl <= ~tgl;
    // unknown pulses count as pulses so they cannot slip through
    if (rst_n_i) begin
      if (wr !== 1'b0) wr_n++;
      if (wr_ref !== 1'b0) ref_n++;
      if (ab !== 1'b0) ab_n++;
      if (fs !== 1'b0) fs_n++;
      if (rx_v && rx_f) first_b = rx_b;
    end
  end
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // watchdog against a hung handshake
  initial begin
    #2000000;
    fail_count++;
    final_report;
  end
  initial begin
    repeat (4) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    m.tick(2);
    `CHK(so_oe, 1'b0)
    `CHK(paused, 1'b0)
    foreach (ROWS[k]) begin
      row = ROWS[k];
      {wp_n_i, lock_i, tx_i} <= {row[11:10], ~row[9:2]};
      w0 = wr_n;
      r0 = ref_n;
      f0 = fs_n;
      first_b = 8'h00;
      m.start(row[12]);
      m.send(8'h01, 8, r);
      m.send(row[9:2], 8, r);
      m.stop;
      `CHK(first_b, 8'h01)
      `CHK(fs_n - f0, 1)
      `CHK(rx_b, row[9:2])
      `CHK(r, ~row[9:2])
      `CHK(wr_n - w0, int'(row[1]))
      `CHK(ref_n - r0, int'(row[0]))
      if (row[1]) `CHK(wr_d, row[9:2])
    end
    // pause mid byte, clock wiggles ignored
    m.start(1'b0);
    m.send(8'h96, 4, r);
    m.pins(1'b1, 1'b0);
    `CHK(paused, 1'b0)
    m.pins(1'b0, 1'b0);
    `CHK(paused, 1'b1)
    `CHK(so_oe, 1'b0)
    m.pins(1'b1, 1'b0);
    `CHK(paused, 1'b1)
    m.pins(1'b0, 1'b1);
    `CHK(paused, 1'b0)
    m.send(8'h60, 4, r);
    m.stop;
    `CHK(rx_b, 8'h96)
    // deselect while paused, then a frame cut off mid byte that aborts
    m.start(1'b1);
    m.send(8'hff, 3, r);
    m.pins(1'b0, 1'b0);
    m.stop;
    `CHK(paused, 1'b0)
    m.pins(1'b1, 1'b1);
    w0 = ab_n;
    m.start(1'b0);
    m.send(8'hc3, 8, r);
    m.send(8'h5a, 5, r);
    m.stop;
    `CHK(rx_b, 8'hc3)
    `CHK(ab_n - w0, 1)
    // reset in mid-frame while paused, then resume on a fresh frame
    m.start(1'b0);
    m.send(8'h81, 8, r);
    m.pins(1'b0, 1'b0);
    rst_n_i <= 1'b0;
    m.tick(4);
    rst_n_i <= 1'b1;
    m.tick(2);
    `CHK(rx_b, 8'h00)
    m.pins(1'b0, 1'b1);
    m.send(8'h3c, 8, r);
    m.stop;
    `CHK(rx_b, 8'h3c)
    // ready/busy on the output, opcode that is not a status write
    w0 = wr_n;
    {auto_i, rbo_i, busy_i} <= 3'h6;
    m.start(1'b0);
    m.send(8'h00, 8, r);
    `CHK(r, 8'hff)
    busy_i <= 1'b1;
    m.send(8'h00, 8, r);
    `CHK(r, 8'h00)
    m.stop;
    `CHK(wr_n - w0, 0)
    final_report;
  end
endmodule
